// ===== src/csioe_pkg.sv
// Constants and state layout of the clocked serial I/O engine
package csioe_pkg;
  // Register byte offsets
  localparam logic [7:0] CSIOE_CTRL_OFS   = 8'h00;
  localparam logic [7:0] CSIOE_STATUS_OFS = 8'h04;
  localparam logic [7:0] CSIOE_TXBUF_OFS  = 8'h08;
  localparam logic [7:0] CSIOE_RXBUF_OFS  = 8'h0c;
  // Control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT  = 1;
  localparam int CTRL_MODE_LSB  = 2;
  localparam int CTRL_ORDER_BIT = 4;
  localparam int CTRL_CSEL_LSB  = 5;
  // Status register fields
  localparam int STAT_TXEMPTY = 0;
  localparam int STAT_RXFULL  = 1;
  localparam int STAT_SHIFT   = 2;
  localparam int STAT_INPROG  = 3;
  localparam int STAT_TX_ERROR_FLAG   = 4;
  localparam int STAT_RX_ERROR_FLAG   = 5;
  // Transfer modes and clock select
  localparam logic [1:0] MODE_TX    = 2'h0;
  localparam logic [1:0] MODE_RX    = 2'h1;
  localparam logic [1:0] MODE_TXRX  = 2'h2;
  localparam logic [2:0] CSEL_EXT   = 3'h7;
  localparam logic       ORDER_MSB  = 1'h0;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  // Internal serial clock: half period is this many cycles shifted by select
  localparam int         SCK_HALF_BASE = 4;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] BUF_RESET     = 8'h00;
  localparam logic [1:0] AHB_NONSEQ    = 2'h2;

  typedef struct packed {
    logic [1:0]  sckSync;
    logic        sckPrev;
    logic [1:0]  siSync;
    logic [9:0]  divCnt;
    logic        sckInt;
    logic        start;
    logic        inhibit;
    logic [1:0]  mode;
    logic        order;
    logic [2:0]  clkSel;
    logic [7:0]  txBuf;
    logic        txFull;
    logic [7:0]  rxBuf;
    logic [7:0]  shReg;
    logic [3:0]  bitCnt;
    logic        loaded;
    logic        txEmpty;
    logic        rxFull;
    logic        shiftAct;
    logic        inProg;
    logic        tx_error_flag;
    logic        rx_error_flag;
    logic        errRead1;
    logic        txIrqPend;
    logic        irq;
    logic        soOut;
    logic        dpValid;
    logic        dpWrite;
    logic [7:0]  dpAddr;
    logic [31:0] rdata;
  } csioe_state_s;
endpackage

// ===== src/csioe_top.sv
// Clocked serial I/O engine: AHB-Lite registers, shifter, serial pins
`timescale 1ns/1ps
module csioe_top
  import csioe_pkg::*;
#(
  parameter int HALF_BASE = SCK_HALF_BASE
) (
  input  wire logic        clk,        // System clock, 100 MHz
  input  wire logic        rst_n,      // Asynchronous reset, active low
  input  wire logic        hsel,       // AHB slave select
  input  wire logic [31:0] haddr,      // AHB address
  input  wire logic [1:0]  htrans,     // AHB transfer type
  input  wire logic        hwrite,     // AHB write
  input  wire logic [2:0]  hsize,      // AHB size, word only
  input  wire logic [31:0] hwdata,     // AHB write data
  input  wire logic        hready,     // AHB bus ready
  output logic      [31:0] hrdata,     // AHB read data
  output logic             hreadyout,  // AHB slave ready
  output logic             hresp,      // AHB response, always OKAY
  input  wire logic        sckIn,      // Serial clock pin input
  output logic             sckOut,     // Serial clock pin output
  output logic             sckOeN,     // Serial clock enable, low drives
  input  wire logic        serialIn,   // Serial data input pin
  output logic             serialOut,  // Serial data output pin
  output logic             serialIrq   // Serial interrupt, one-cycle pulse
);

  // Larger bases overflow the ten-bit divider at select 6
  if (HALF_BASE < 1 || (HALF_BASE << 6) > 1023) begin : gHalfChk
    $error("HALF_BASE out of range");
  end

  csioe_state_s s_r;
  csioe_state_s s_nxt;

  logic       extClk;
  logic       txMode;
  logic       rxMode;
  logic       modeOk;
  logic       fallEv;
  logic       riseEv;
  logic       tick;
  logic       permit;
  logic       goFall;
  logic [9:0] halfCycles;
  logic [7:0] shSrc;
  logic [7:0] shIn;
  logic       addrAcc;
  logic [31:0] rdVal;

  always_comb begin
    s_nxt = s_r;
    extClk = (s_r.clkSel == CSEL_EXT);
    txMode = (s_r.mode == MODE_TX) || (s_r.mode == MODE_TXRX);
    rxMode = (s_r.mode == MODE_RX) || (s_r.mode == MODE_TXRX);
    modeOk = (s_r.mode != 2'h3);
    halfCycles = 10'(HALF_BASE << s_r.clkSel);
    shSrc = s_r.shReg;
    shIn = s_r.shReg;
    rdVal = 32'h0;
    addrAcc = hsel && htrans[1] && hready;

    // Pin synchronisers; only the second stage is read
    s_nxt.sckSync = {s_r.sckSync[0], sckIn};
    s_nxt.sckPrev = s_r.sckSync[1];
    s_nxt.siSync = {s_r.siSync[0], serialIn};
    s_nxt.irq = 1'b0;

    // Internal clock divider, free running tick
    tick = (s_r.divCnt == 10'h0);
    s_nxt.divCnt = tick ? halfCycles - 10'h1 : s_r.divCnt - 10'h1;

    // park conditions before the next byte
    // full duplex needs both read and write
    permit = s_r.start && modeOk
           && (!txMode || s_r.txFull) && (!rxMode || !s_r.rxFull);
    goFall = (s_r.bitCnt != 4'h0) || permit;
    // external clock when select is 111B
    if (extClk) begin
      fallEv = s_r.sckPrev && !s_r.sckSync[1];
      riseEv = !s_r.sckPrev && s_r.sckSync[1];
    end else begin
      // next tick drives the first falling edge
      fallEv = tick && s_r.sckInt && goFall;
      riseEv = tick && !s_r.sckInt;
      if (fallEv) begin
        s_nxt.sckInt = 1'b0;
      end
      if (riseEv) begin
        s_nxt.sckInt = 1'b1;
      end
    end

    // AHB address phase: read data and read side effects
    s_nxt.dpValid = addrAcc;
    s_nxt.dpWrite = hwrite;
    s_nxt.dpAddr = haddr[7:0];
    if (addrAcc && !hwrite) begin
      unique case (haddr[7:0])
        CSIOE_CTRL_OFS: begin
          rdVal[CTRL_START_BIT] = s_r.start;
          rdVal[CTRL_STOP_BIT] = s_r.inhibit;
          rdVal[CTRL_MODE_LSB +: 2] = s_r.mode;
          rdVal[CTRL_ORDER_BIT] = s_r.order;
          rdVal[CTRL_CSEL_LSB +: 3] = s_r.clkSel;
        end
        CSIOE_STATUS_OFS: begin
          rdVal[STAT_TXEMPTY] = s_r.txEmpty;
          rdVal[STAT_RXFULL] = s_r.rxFull;
          rdVal[STAT_SHIFT] = s_r.shiftAct;
          rdVal[STAT_INPROG] = s_r.inProg;
          rdVal[STAT_TX_ERROR_FLAG] = s_r.tx_error_flag;
          rdVal[STAT_RX_ERROR_FLAG] = s_r.rx_error_flag;
        end
        CSIOE_RXBUF_OFS: begin
          // second read in error shows the shifter
          if (s_r.rx_error_flag && s_r.errRead1) begin
            rdVal[7:0] = s_r.shReg;
          end else begin
            rdVal[7:0] = s_r.rxBuf;
          end
          if (s_r.rx_error_flag) begin
            s_nxt.errRead1 = 1'b1;
          end else begin
            s_nxt.rxFull = 1'b0;
          end
        end
        default: rdVal = 32'h0;
      endcase
    end
    s_nxt.rdata = addrAcc ? rdVal : s_r.rdata;

    // AHB data phase: writes
    if (s_r.dpValid && s_r.dpWrite) begin
      unique case (s_r.dpAddr)
        CSIOE_CTRL_OFS: begin
          s_nxt.start = hwdata[CTRL_START_BIT];
          s_nxt.inhibit = hwdata[CTRL_STOP_BIT];
          s_nxt.mode = hwdata[CTRL_MODE_LSB +: 2];
          s_nxt.order = hwdata[CTRL_ORDER_BIT];
          s_nxt.clkSel = hwdata[CTRL_CSEL_LSB +: 3];
        end
        CSIOE_STATUS_OFS: begin
          // clearing the error also clears full
          if (hwdata[STAT_RX_ERROR_FLAG]) begin
            s_nxt.rx_error_flag = 1'b0;
            s_nxt.rxFull = 1'b0;
            s_nxt.errRead1 = 1'b0;
          end
        end
        CSIOE_TXBUF_OFS: begin
          s_nxt.txBuf = hwdata[7:0];
          s_nxt.txFull = 1'b1;
          s_nxt.txEmpty = 1'b0;
        end
        default: s_nxt.start = s_nxt.start;
      endcase
    end

    // Engine updates follow bus clears, so a set wins
    // start cleared: stop at the byte boundary
    // also in error, once the running byte ends
    if (s_r.inProg && s_r.bitCnt == 4'h0 && !s_r.start) begin
      s_nxt.inProg = 1'b0;
      s_nxt.soOut = 1'b1;
    end

    // Falling serial clock: start a byte or shift out
    if (fallEv && modeOk) begin
      if (s_r.txIrqPend && !s_r.rx_error_flag) begin
        // irq on the fall after the error
        s_nxt.irq = 1'b1;
      end
      s_nxt.txIrqPend = 1'b0;
      if (s_r.bitCnt == 4'h0 && s_r.start) begin
        s_nxt.inProg = 1'b1;
        s_nxt.shiftAct = 1'b1;
        s_nxt.bitCnt = 4'h1;
        if (txMode && !s_r.rx_error_flag) begin
          if (!s_r.txFull) begin
            // shift began with no new data
            s_nxt.tx_error_flag = 1'b1;
            s_nxt.txIrqPend = 1'b1;
          end else begin
            // load on the first falling edge
            shSrc = s_r.txBuf;
            s_nxt.shReg = s_r.txBuf;
            s_nxt.txFull = 1'b0;
            s_nxt.loaded = 1'b1;
          end
        end
      end else if (s_r.bitCnt != 4'h0 && s_r.bitCnt < BYTE_BITS) begin
        s_nxt.bitCnt = s_r.bitCnt + 4'h1;
      end
      if (s_r.bitCnt < BYTE_BITS && (s_r.bitCnt != 4'h0 || s_r.start)) begin
        // order bit picks the outgoing end
        if (txMode) begin
          s_nxt.soOut = (s_r.order == ORDER_MSB) ? shSrc[7] : shSrc[0];
        end else begin
          s_nxt.soOut = 1'b1;
        end
      end
    end

    // Rising serial clock: sample input, finish the byte
    if (riseEv && s_r.inProg && s_r.bitCnt != 4'h0) begin
      if (s_r.loaded) begin
        // empty set on the rise after loading
        s_nxt.txEmpty = 1'b1;
        s_nxt.loaded = 1'b0;
      end
      // sample on rise, assemble in chosen order
      shIn = (s_r.order == ORDER_MSB) ? {s_r.shReg[6:0], s_r.siSync[1]}
                                      : {s_r.siSync[1], s_r.shReg[7:1]};
      // data ignored while receive error stands
      if (!s_r.rx_error_flag) begin
        s_nxt.shReg = shIn;
      end
      if (s_r.bitCnt == BYTE_BITS) begin
        // shift-active ends on the eighth rise
        s_nxt.bitCnt = 4'h0;
        s_nxt.shiftAct = 1'b0;
        // no irq once receive error stands
        if (rxMode && !s_r.rx_error_flag) begin
          if (s_r.rxFull) begin
            s_nxt.rx_error_flag = 1'b1;
            s_nxt.errRead1 = 1'b0;
            s_nxt.irq = 1'b1;
          end else begin
            // byte to buffer, full flag, irq
            s_nxt.rxBuf = shIn;
            s_nxt.rxFull = 1'b1;
            s_nxt.irq = 1'b1;
          end
        end else if (!rxMode && !s_r.rx_error_flag) begin
          s_nxt.irq = 1'b1;
        end
      end
    end

    // output held high under transmit error
    if (s_nxt.tx_error_flag) begin
      s_nxt.soOut = 1'b1;
    end

    // inhibit stops at once and initialises
    if (s_nxt.inhibit) begin
      s_nxt.start = 1'b0;
      s_nxt.txBuf = BUF_RESET;
      s_nxt.rxBuf = BUF_RESET;
      s_nxt.txFull = 1'b0;
      s_nxt.bitCnt = 4'h0;
      s_nxt.loaded = 1'b0;
      s_nxt.txEmpty = 1'b0;
      s_nxt.rxFull = 1'b0;
      s_nxt.shiftAct = 1'b0;
      s_nxt.inProg = 1'b0;
      s_nxt.tx_error_flag = 1'b0;
      s_nxt.rx_error_flag = 1'b0;
      s_nxt.errRead1 = 1'b0;
      s_nxt.txIrqPend = 1'b0;
      s_nxt.irq = 1'b0;
      s_nxt.soOut = 1'b1;
      s_nxt.sckInt = 1'b1;
    end
  end

  // reset: flags clear, clock and data idle high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{sckSync: 2'h3, sckPrev: 1'b1, siSync: 2'h3, divCnt: 10'h0,
               sckInt: 1'b1, start: 1'b0, inhibit: 1'b0, mode: 2'h0,
               order: 1'b0, clkSel: 3'h0, txBuf: BUF_RESET, txFull: 1'b0,
               rxBuf: BUF_RESET, shReg: 8'h00, bitCnt: 4'h0, loaded: 1'b0,
               txEmpty: 1'b0, rxFull: 1'b0, shiftAct: 1'b0, inProg: 1'b0,
               tx_error_flag: 1'b0, rx_error_flag: 1'b0, errRead1: 1'b0, txIrqPend: 1'b0,
               irq: 1'b0, soOut: 1'b1, dpValid: 1'b0, dpWrite: 1'b0,
               dpAddr: 8'h00, rdata: 32'h0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hrdata    = s_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign sckOut    = s_r.sckInt;
  assign sckOeN    = (s_r.clkSel == CSEL_EXT);
  assign serialOut = s_r.soOut;
  assign serialIrq = s_r.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  txErrSoHigh_a: assert property (s_r.tx_error_flag |-> serialOut)
    else $error("output not high under transmit error");

  inhibitInit_a: assert property (s_r.inhibit |->
      !s_r.start && !s_r.rxFull && !s_r.tx_error_flag && !s_r.rx_error_flag && !s_r.inProg
      && s_r.rxBuf == 8'h00 && s_r.txBuf == 8'h00)
    else $error("inhibit did not initialise");

  parkHigh_a: assert property ((!s_r.inProg && sckOeN == 1'b0) |-> sckOut)
    else $error("internal clock not parked high");

  fullIrq_a: assert property ($rose(s_r.rxFull) |-> serialIrq)
    else $error("receive full without irq");

  errFreeze_a: assert property ((s_r.rx_error_flag && $past(s_r.rx_error_flag)) |->
      $stable(s_r.rxBuf) && $stable(s_r.shReg))
    else $error("data changed under receive error");

  errNoIrq_a: assert property ((s_r.rx_error_flag && $past(s_r.rx_error_flag)) |-> !serialIrq)
    else $error("irq while receive error stands");

  shiftSpan_a: assert property (s_r.shiftAct |->
      (s_r.bitCnt != 4'h0 && s_r.bitCnt <= BYTE_BITS))
    else $error("shift-active outside a byte");

  emptyAfterLoad_a: assert property ($rose(s_r.txEmpty) |-> $past(s_r.loaded))
    else $error("empty flag without a prior load");

  errIrqNext_a: assert property ($rose(s_r.tx_error_flag) && !s_r.rx_error_flag |->
      s_r.txIrqPend)
    else $error("transmit error irq not armed");

  progOnFall_a: assert property ($rose(s_r.inProg) |-> $past(fallEv))
    else $error("in-progress rose off a falling edge");

  stopHigh_a: assert property ($fell(s_r.inProg) |-> serialOut)
    else $error("output not high after stop");

  clkStart_a: assert property ((!extClk && permit && s_r.bitCnt == 4'h0) |->
      ##[0:600] (!sckOut || !permit || extClk))
    else $error("internal clock did not start");

  byteDone_c:  cover property ($rose(s_r.rxFull) && s_r.mode == MODE_TXRX);
  overrun_c:   cover property ($rose(s_r.rx_error_flag));
  txError_c:   cover property ($rose(s_r.tx_error_flag));
  inhibit_c:   cover property ($rose(s_r.inhibit) && $past(s_r.inProg));
  stop_c:      cover property ($fell(s_r.inProg) && !s_r.inhibit);

endmodule

// ===== dv/csioe_partner.sv
// Behavioural far-side serial device for the serial I/O engine bench
`timescale 1ns/1ps
module csioe_partner (
  input  wire logic sckOut,     // Device clock output
  input  wire logic serialOut,  // Device data output
  input  wire logic extClk,     // Partner supplies the clock
  input  wire logic lsbFirst,   // Bit order, 1 LSB first
  output logic      sckIn,      // Clock to device
  output logic      serialIn    // Data to device
);
  logic [7:0] txByte;
  logic [7:0] rxByte;
  int         bitIdx;
  logic       sck;

  assign sck = extClk ? sckIn : sckOut;

  initial begin
    sckIn = 1'b1;
    serialIn = 1'b1;
    txByte = 8'h00;
    rxByte = 8'h00;
    bitIdx = 8;
  end

  task automatic load(input logic [7:0] b);
    txByte = b;
    bitIdx = 0;
  endtask

  task automatic clockByte();
    #3;
    repeat (8) begin
      #62.5 sckIn = 1'b0;
      #62.5 sckIn = 1'b1;
    end
    #62.5;
  endtask

  // Data set on fall, held over rise
  always @(negedge sck) begin
    if (bitIdx < 8) serialIn <= lsbFirst ? txByte[bitIdx] : txByte[7 - bitIdx];
    else serialIn <= ~serialIn;  // Released line must not look stable
  end

  always @(posedge sck) begin
    rxByte <= lsbFirst ? {serialOut, rxByte[7:1]} : {rxByte[6:0], serialOut};
    if (bitIdx < 8) bitIdx <= bitIdx + 1;
  end
endmodule

// ===== dv/test_csioe_top.sv
// Self-checking bench of the clocked serial I/O engine
`timescale 1ns/1ps
`define CHK(got, exp) begin cmpCount++; if ((got) !== (exp)) begin badCount++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module test_csioe_top;
  import csioe_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0]  hsize = 3'h0;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        sckIn;
  logic        sckOut;
  logic        sckOeN;
  logic        serialIn;
  logic        serialOut;
  logic        serialIrq;
  logic        extClk = 1'b0;
  logic        lsbFirst = 1'b0;
  logic [31:0] rdat;
  int          badCount = 0;
  int          cmpCount = 0;
  int          cycles = 0;
  int          irqCount = 0;

  assign hready = hreadyout;

  csioe_top i_csioe_top (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sckIn(sckIn),
    .sckOut(sckOut), .sckOeN(sckOeN), .serialIn(serialIn), .serialOut(serialOut),
    .serialIrq(serialIrq));

  csioe_partner i_csioe_partner (.sckOut(sckOut), .serialOut(serialOut), .extClk(extClk),
    .lsbFirst(lsbFirst), .sckIn(sckIn), .serialIn(serialIn));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (serialIrq === 1'b1) irqCount++;
    if (cycles == 20000) begin
      badCount++;
      printVerdict();
    end
  end

  task automatic printVerdict();
    $display("Checks %0d, mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= AHB_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    hsize  <= 3'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    ahb(1'b1, a, {24'h0, d}, x);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, rdat);
    `CHK(rdat & m, e)
  endtask

  // Bounded wait for at least n interrupt pulses since mark s
  task automatic waitIrq(input int s, input int n);
    repeat (3000) begin
      if (irqCount - s >= n) break;
      @(posedge clk);
    end
    `CHK(irqCount - s >= n, 1'b1)
  endtask

  task automatic resetCheck();
    `CHK({sckOut, serialOut, serialIrq, hresp}, 4'b1100)
    rdChk(CSIOE_STATUS_OFS, 32'h3f, 32'h0);
  endtask

  task automatic fullDuplex();
    int s;
    i_csioe_partner.load(8'h3c);
    wr(CSIOE_TXBUF_OFS, 8'ha5);
    s = irqCount;
    wr(CSIOE_CTRL_OFS, 8'h09);
    waitIrq(s, 1);
    `CHK(i_csioe_partner.rxByte, 8'ha5)
    rdChk(CSIOE_STATUS_OFS, 32'h3f, 32'h0b);
    repeat (40) @(posedge clk);
    `CHK(sckOut, 1'b1)
    wr(CSIOE_CTRL_OFS, 8'h08);
    rdChk(CSIOE_RXBUF_OFS, 32'hff, 32'h3c);
    rdChk(CSIOE_STATUS_OFS, 32'h0a, 32'h00);
    `CHK(serialOut, 1'b1)
    wr(CSIOE_TXBUF_OFS, 8'h11);
    rdChk(CSIOE_STATUS_OFS, 32'h01, 32'h00);
  endtask

  task automatic rxInternal();
    int s;
    int n;
    lsbFirst = 1'b1;
    i_csioe_partner.load(8'h13);
    s = irqCount;
    wr(CSIOE_CTRL_OFS, 8'h15);
    waitIrq(s, 1);
    repeat (40) @(posedge clk);
    `CHK(sckOut, 1'b1)
    // Reading the buffer releases the parked clock for a second byte
    i_csioe_partner.load(8'h2d);
    s = irqCount;
    rdChk(CSIOE_RXBUF_OFS, 32'hff, 32'h13);
    n = 0;
    while (sckOut === 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    `CHK(n < 9, 1'b1)
    wr(CSIOE_CTRL_OFS, 8'h14);
    waitIrq(s, 1);
    rdChk(CSIOE_RXBUF_OFS, 32'hff, 32'h2d);
    repeat (40) @(posedge clk);
    rdChk(CSIOE_STATUS_OFS, 32'h0a, 32'h00);
    lsbFirst = 1'b0;
  endtask

  task automatic txErrExt();
    int s;
    // Inhibit drops the byte still pending from before
    wr(CSIOE_CTRL_OFS, 8'h02);
    wr(CSIOE_CTRL_OFS, 8'h00);
    extClk = 1'b1;
    wr(CSIOE_CTRL_OFS, 8'he1);
    s = irqCount;
    i_csioe_partner.clockByte();
    `CHK(sckOeN, 1'b1)
    `CHK(i_csioe_partner.rxByte, 8'hff)
    waitIrq(s, 1);
    rdChk(CSIOE_STATUS_OFS, 32'h10, 32'h10);
    wr(CSIOE_CTRL_OFS, 8'h02);
    rdChk(CSIOE_STATUS_OFS, 32'h3f, 32'h00);
    rdChk(CSIOE_CTRL_OFS, 32'h01, 32'h00);
    wr(CSIOE_CTRL_OFS, 8'h00);
  endtask

  task automatic overrunExt();
    int s;
    wr(CSIOE_CTRL_OFS, 8'he5);
    s = irqCount;
    i_csioe_partner.load(8'h5a);
    i_csioe_partner.clockByte();
    waitIrq(s, 1);
    rdChk(CSIOE_STATUS_OFS, 32'h22, 32'h02);
    s = irqCount;
    i_csioe_partner.load(8'hc3);
    i_csioe_partner.clockByte();
    waitIrq(s, 1);
    rdChk(CSIOE_STATUS_OFS, 32'h20, 32'h20);
    s = irqCount;
    i_csioe_partner.load(8'h77);
    i_csioe_partner.clockByte();
    repeat (20) @(posedge clk);
    `CHK(irqCount - s, 0)
    wr(CSIOE_CTRL_OFS, 8'he4);
    rdChk(CSIOE_RXBUF_OFS, 32'hff, 32'h5a);
    rdChk(CSIOE_RXBUF_OFS, 32'hff, 32'hc3);
    wr(CSIOE_STATUS_OFS, 8'h20);
    rdChk(CSIOE_STATUS_OFS, 32'h22, 32'h00);
    i_csioe_partner.load(8'h00);
    i_csioe_partner.clockByte();
    rdChk(CSIOE_STATUS_OFS, 32'h08, 32'h00);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    resetCheck();
    fullDuplex();
    rxInternal();
    txErrExt();
    overrunExt();
    printVerdict();
  end
endmodule
